// ### cic_core.sv
// interrupt controller of an 8-bit core: flags, enables, vectoring, shadows, wake
//
// Contract
// RL1: any reset leaves every interrupt enable cleared, no vectoring.
// RL2: vectoring needs global enable and own enable; peripherals also group enable.
// RL3: flags set on their events whatever the enables hold.
// RL4: entry flushes prefetch, clears global enable, pushes PC, saves context, vectors 0004h.
// RL5: with global enable clear only flags set; pending serviced once re-enabled.
// RL6: return pops address, restores shadows and sets global enable.
// RL7: service routine polls flags and clears them before returning.
// RL8: synchronous sources reach the vector in three or four instruction cycles.
// RL9: asynchronous sources reach the vector in three to five instruction cycles.
// RL10: latency is the same for one and two cycle instructions.
// RL11: pin flag sampled at every phase one; may set during phase four to one.
// RL12: software enables a wake source before sleep; only clockless sources wake.
// RL13: on wake, vector if global enable set, else continue after sleep.
// RL14: instruction after sleep always executes before any vectoring.
// RL15: external pin gives edge-triggered interrupt enabled by its own bit.
// RL16: edge select set means rising edge, clear means falling edge.
// RL17: selected edge sets pin flag; vector only with global and pin enable.
// RL18: entry copies accumulator, status less timeout/powerdown, bank, pointers, pc high latch.
// RL19: return restores from shadows, so shadow writes are what come back.
// RL20: shadows sit in bank 31 and are readable and writable.
// RL21: global enable is control bit 7, group enable bit 6, both reset clear.
// RL22: change summary flag is read-only, clears when all pin change flags clear.
// RL23: request is OR of flag-and-enable terms, peripherals gated by group enable.
// RL24: external pin is synchronised into the core clock before setting its flag.
`timescale 1ns/100ps
`include "cic_consts.svh"
module cic_core import cic_pkg::*; #(
    parameter int NPIN = 8
) (
    input  wire logic             CORE_CLK,
    input  wire logic             RST_N,
    input  wire logic [6:0]       ADDR,
    input  wire logic [7:0]       WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output logic      [7:0]       RDATA,
    input  wire logic             EXT_PIN,
    input  wire logic             TMR_OVF,
    input  wire logic [23:0]      PERIPH_EVENT,
    input  wire logic [NPIN-1:0]  PIN_CHANGE,
    input  wire logic             INSTR_BOUNDARY,
    input  wire logic             SLEEP_EXEC,
    input  wire logic             RETURN_EXEC,
    input  wire logic [7:0]       CORE_W,
    input  wire logic [7:0]       CORE_STATUS,
    input  wire logic [5:0]       CORE_BANK,
    input  wire logic [6:0]       CORE_PC_HIGH_LATCH,
    input  wire logic [31:0]      CORE_PTRS,
    output logic                  FLUSH,
    output logic                  PUSH_PC,
    output logic                  LOAD_VECTOR,
    output logic      [14:0]      VECTOR_ADDR,
    output logic                  POP_PC,
    output logic                  RESTORE,
    output logic      [7:0]       RESTORE_W,
    output logic      [7:0]       RESTORE_STATUS,
    output logic      [5:0]       RESTORE_BANK,
    output logic      [6:0]       RESTORE_PC_HIGH_LATCH,
    output logic      [31:0]      RESTORE_PTRS,
    output logic                  SLEEPING,
    output logic                  IRQ_PENDING,
    output logic                  Q1_PHASE
);
    cic_state_t     state_q;
    cic_state_t     state_d;
    logic [7:0]     ctrl_q;
    logic [7:0]     en_q [3];
    logic [7:0]     fl_q [3];
    logic           edge_sel_q;
    logic [NPIN-1:0] cn_fl_q;
    logic [NPIN-1:0] cn_en_q;
    logic [7:0]     shd_w_q;
    logic [7:0]     shd_st_q;
    logic [5:0]     shd_bank_q;
    logic [6:0]     shd_pcl_q;
    logic [31:0]    shd_ptr_q;
    logic           pin_flag_seen_q;
    logic [1:0]     cnt_q;
    logic [7:0]     rdata_q;
    logic           pin_edge;
    logic           q1;
    logic           q4;

    function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
        return a == off;
    endfunction

    cic_edge_sync u_sync (
        .CLK      (CORE_CLK),
        .RST_N    (RST_N),
        .PIN      (EXT_PIN),
        .RISE_SEL (edge_sel_q),
        .EDGE     (pin_edge)
    );  // see RL24

    cic_phase_gen u_phase (
        .CLK   (CORE_CLK),
        .RST_N (RST_N),
        .Q1    (q1),
        .Q4    (q4)
    );

    // decode
    wire wr_ctrl = WR & hit(ADDR, `CIC_OFF_CTRL);
    wire wr_edge = WR & hit(ADDR, `CIC_OFF_EDGE);
    wire wr_cnf  = WR & hit(ADDR, `CIC_OFF_CN_FLAGS);
    wire wr_cne  = WR & hit(ADDR, `CIC_OFF_CN_EN);
    wire wr_sw   = WR & hit(ADDR, `CIC_OFF_SHD_W);
    wire wr_sst  = WR & hit(ADDR, `CIC_OFF_SHD_STATUS);
    wire wr_sbk  = WR & hit(ADDR, `CIC_OFF_SHD_BANK);
    wire wr_spc  = WR & hit(ADDR, `CIC_OFF_SHD_PC_HIGH_LATCH);
    wire [3:0] wr_sp;
    wire [2:0] wr_en;
    wire [2:0] wr_fl;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ptr
            assign wr_sp[g] = WR & hit(ADDR, 7'(`CIC_OFF_SHD_PTR0L + g));
        end
        for (g = 0; g < 3; g++) begin : g_per
            assign wr_en[g] = WR & hit(ADDR, 7'(`CIC_OFF_EN_A + g));
            assign wr_fl[g] = WR & hit(ADDR, 7'(`CIC_OFF_FL_A + g));
            always_ff @(posedge CORE_CLK) begin
                if (!RST_N) begin
                    en_q[g] <= 8'h00;  // see RL1
                    fl_q[g] <= 8'h00;
                end else begin
                    if (wr_en[g]) en_q[g] <= WDATA;
                    // events win over a software clear in the same cycle; see RL3
                    fl_q[g] <= (wr_fl[g] ? WDATA : fl_q[g]) | PERIPH_EVENT[8*g +: 8];
                end
            end
        end
    endgenerate

    // request forming
    wire cn_summary = |(cn_fl_q & cn_en_q);  // see RL22
    wire [7:0] ctrl_view = {ctrl_q[7:1], cn_summary};
    wire core_req = (ctrl_q[`CIC_BIT_TMR_EN] & ctrl_q[`CIC_BIT_TMR_FL])
                  | (ctrl_q[`CIC_BIT_PIN_EN] & ctrl_q[`CIC_BIT_PIN_FL])  // see RL17
                  | (ctrl_q[`CIC_BIT_CN_EN] & cn_summary);
    wire per_req  = |((fl_q[0] & en_q[0]) | (fl_q[1] & en_q[1]) | (fl_q[2] & en_q[2]));
    wire any_req  = core_req | (ctrl_q[`CIC_BIT_PGE] & per_req);  // see RL2, RL23
    wire global_irq_enable      = ctrl_q[`CIC_BIT_GIE];
    // vectoring looks at the pin flag and every other request only at phase one; see RL11
    wire take     = global_irq_enable & any_req & INSTR_BOUNDARY & (state_q == CIC_RUN) & q1;  // see RL5, RL8, RL9
    wire entry    = (state_q == CIC_FLUSH) & (cnt_q == 2'h0);

    // sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            CIC_RUN: begin
                if (take) state_d = CIC_FLUSH;
                else if (SLEEP_EXEC) state_d = CIC_SLEEP;
            end
            CIC_FLUSH: begin
                if (cnt_q == 2'h0) state_d = CIC_RUN;
            end
            CIC_SLEEP: begin
                if (any_req) state_d = CIC_WAKE;  // see RL12
            end
            CIC_WAKE: begin
                // next instruction runs first; vectoring then follows from RUN; see RL13, RL14
                if (INSTR_BOUNDARY) state_d = CIC_RUN;
            end
            default: state_d = CIC_RUN;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_q <= CIC_RUN;
            cnt_q   <= 2'h0;
        end else begin
            state_q <= state_d;
            // fixed entry length whatever instruction was running; see RL10
            if (take) cnt_q <= `CIC_ENTRY_CYCLES;
            else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
        end
    end

    // control register
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ctrl_q <= `CIC_RST_CTRL;  // see RL1, RL21
        end else begin
            if (wr_ctrl) ctrl_q[7:1] <= WDATA[7:1];
            if (take) ctrl_q[`CIC_BIT_GIE] <= 1'b0;  // see RL4
            else if (RETURN_EXEC) ctrl_q[`CIC_BIT_GIE] <= 1'b1;  // see RL6
            if (TMR_OVF) ctrl_q[`CIC_BIT_TMR_FL] <= 1'b1;
            if (pin_edge & (q4 | q1)) ctrl_q[`CIC_BIT_PIN_FL] <= 1'b1;  // see RL15, RL16, RL17
            if (pin_flag_seen_q & q4) ctrl_q[`CIC_BIT_PIN_FL] <= 1'b1;
            ctrl_q[0] <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) pin_flag_seen_q <= 1'b0;
        else if (pin_edge & ~(q4 | q1)) pin_flag_seen_q <= 1'b1;
        else if (q4) pin_flag_seen_q <= 1'b0;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            edge_sel_q <= 1'b1;
            cn_en_q    <= '0;
            cn_fl_q    <= '0;
        end else begin
            if (wr_edge) edge_sel_q <= WDATA[0];
            if (wr_cne) cn_en_q <= WDATA[NPIN-1:0];
            cn_fl_q <= (wr_cnf ? WDATA[NPIN-1:0] : cn_fl_q) | PIN_CHANGE;
        end
    end

    // shadow copies
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            shd_w_q    <= 8'h00;
            shd_st_q   <= 8'h00;
            shd_bank_q <= 6'h00;
            shd_pcl_q  <= 7'h00;
            shd_ptr_q  <= 32'h0;
        end else if (take) begin
            shd_w_q    <= CORE_W;  // see RL18
            shd_st_q   <= CORE_STATUS & `CIC_STATUS_KEEP;
            shd_bank_q <= CORE_BANK;
            shd_pcl_q  <= CORE_PC_HIGH_LATCH;
            shd_ptr_q  <= CORE_PTRS;
        end else begin
            if (wr_sw) shd_w_q <= WDATA;  // see RL20
            if (wr_sst) shd_st_q <= WDATA & `CIC_STATUS_KEEP;
            if (wr_sbk) shd_bank_q <= WDATA[5:0];
            if (wr_spc) shd_pcl_q <= WDATA[6:0];
            for (int i = 0; i < 4; i++) begin
                if (wr_sp[i]) shd_ptr_q[8*i +: 8] <= WDATA;
            end
        end
    end

    // read port
    wire [7:0] rd_mux =
        hit(ADDR, `CIC_OFF_CTRL)       ? ctrl_view :
        hit(ADDR, `CIC_OFF_EN_A)       ? en_q[0] :
        hit(ADDR, `CIC_OFF_EN_B)       ? en_q[1] :
        hit(ADDR, `CIC_OFF_EN_C)       ? en_q[2] :
        hit(ADDR, `CIC_OFF_FL_A)       ? fl_q[0] :
        hit(ADDR, `CIC_OFF_FL_B)       ? fl_q[1] :
        hit(ADDR, `CIC_OFF_FL_C)       ? fl_q[2] :
        hit(ADDR, `CIC_OFF_EDGE)       ? {7'h00, edge_sel_q} :
        hit(ADDR, `CIC_OFF_CN_FLAGS)   ? 8'(cn_fl_q) :
        hit(ADDR, `CIC_OFF_CN_EN)      ? 8'(cn_en_q) :
        hit(ADDR, `CIC_OFF_SHD_W)      ? shd_w_q :
        hit(ADDR, `CIC_OFF_SHD_STATUS) ? shd_st_q :
        hit(ADDR, `CIC_OFF_SHD_BANK)   ? {2'h0, shd_bank_q} :
        hit(ADDR, `CIC_OFF_SHD_PC_HIGH_LATCH) ? {1'h0, shd_pcl_q} :
        hit(ADDR, `CIC_OFF_SHD_PTR0L)  ? shd_ptr_q[7:0] :
        hit(ADDR, `CIC_OFF_SHD_PTR0H)  ? shd_ptr_q[15:8] :
        hit(ADDR, `CIC_OFF_SHD_PTR1L)  ? shd_ptr_q[23:16] :
        hit(ADDR, `CIC_OFF_SHD_PTR1H)  ? shd_ptr_q[31:24] : 8'h00;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) rdata_q <= 8'h00;
        else if (RD) rdata_q <= rd_mux;
        else rdata_q <= 8'h00;
    end

    assign RDATA          = rdata_q;
    assign FLUSH          = take;  // see RL4
    assign PUSH_PC        = take;
    assign LOAD_VECTOR    = entry;
    assign VECTOR_ADDR    = `CIC_VECTOR;
    assign POP_PC         = RETURN_EXEC;  // see RL6
    assign RESTORE        = RETURN_EXEC;  // see RL19
    assign RESTORE_W      = shd_w_q;
    assign RESTORE_STATUS = shd_st_q;
    assign RESTORE_BANK   = shd_bank_q;
    assign RESTORE_PC_HIGH_LATCH = shd_pcl_q;
    assign RESTORE_PTRS   = shd_ptr_q;
    assign SLEEPING       = (state_q == CIC_SLEEP);
    assign IRQ_PENDING    = global_irq_enable & any_req;
    assign Q1_PHASE       = q1;
endmodule

// ### cic_consts.svh
// constants of the core interrupt controller
`ifndef CIC_CONSTS_SVH
`define CIC_CONSTS_SVH
`define CIC_ADDR_W          7
`define CIC_OFF_CTRL        7'h0b
`define CIC_OFF_EN_A        7'h11
`define CIC_OFF_EN_B        7'h12
`define CIC_OFF_EN_C        7'h13
`define CIC_OFF_FL_A        7'h14
`define CIC_OFF_FL_B        7'h15
`define CIC_OFF_FL_C        7'h16
`define CIC_OFF_EDGE        7'h17
`define CIC_OFF_CN_FLAGS    7'h18
`define CIC_OFF_CN_EN       7'h19
`define CIC_OFF_SHD_W       7'h64
`define CIC_OFF_SHD_STATUS  7'h65
`define CIC_OFF_SHD_BANK    7'h66
`define CIC_OFF_SHD_PC_HIGH_LATCH  7'h67
`define CIC_OFF_SHD_PTR0L   7'h68
`define CIC_OFF_SHD_PTR0H   7'h69
`define CIC_OFF_SHD_PTR1L   7'h6a
`define CIC_OFF_SHD_PTR1H   7'h6b
`define CIC_BIT_GIE         7
`define CIC_BIT_PGE         6
`define CIC_BIT_TMR_EN      5
`define CIC_BIT_PIN_EN      4
`define CIC_BIT_CN_EN       3
`define CIC_BIT_TMR_FL      2
`define CIC_BIT_PIN_FL      1
`define CIC_BIT_CN_FL       0
`define CIC_RST_CTRL        8'h00
`define CIC_STATUS_KEEP     8'he7
`define CIC_VECTOR          15'h0004
`define CIC_ENTRY_CYCLES    2'h2
`endif

// ### cic_pkg.sv
// types of the core interrupt controller
package cic_pkg;
    typedef enum logic [3:0] {
        CIC_RUN   = 4'b0001,
        CIC_FLUSH = 4'b0010,
        CIC_SLEEP = 4'b0100,
        CIC_WAKE  = 4'b1000
    } cic_state_t;
    typedef logic [7:0] cic_byte_t;
endpackage

// ### cic_edge_sync.sv
// synchroniser and edge detector for the external interrupt pin
`timescale 1ns/100ps
module cic_edge_sync (
    input  wire logic CLK,
    input  wire logic RST_N,
    input  wire logic PIN,
    input  wire logic RISE_SEL,
    output logic      EDGE
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    wire  rise = s2_q & ~s3_q;
    wire  fall = ~s2_q & s3_q;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= PIN;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign EDGE = RISE_SEL ? rise : fall;
endmodule

// ### cic_phase_gen.sv
// quadrature phase generator: four core clocks per instruction cycle
`timescale 1ns/100ps
module cic_phase_gen (
    input  wire logic CLK,
    input  wire logic RST_N,
    output logic      Q1,
    output logic      Q4
);
    logic [1:0] ph_q;
    always_ff @(posedge CLK) begin
        if (!RST_N) ph_q <= 2'h0;
        else ph_q <= ph_q + 2'h1;
    end
    assign Q1 = (ph_q == 2'h0);
    assign Q4 = (ph_q == 2'h3);
endmodule

// ### cic_core_properties.sv
// port checker of the core interrupt controller
`timescale 1ns/100ps
module cic_core_chk (
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic        RETURN_EXEC,
    input wire logic        INSTR_BOUNDARY,
    input wire logic [7:0]  CORE_W,
    input wire logic [7:0]  CORE_STATUS,
    input wire logic        FLUSH,
    input wire logic        PUSH_PC,
    input wire logic        LOAD_VECTOR,
    input wire logic [14:0] VECTOR_ADDR,
    input wire logic        POP_PC,
    input wire logic        RESTORE,
    input wire logic [7:0]  RESTORE_W,
    input wire logic [7:0]  RESTORE_STATUS,
    input wire logic        IRQ_PENDING,
    input wire logic        Q1_PHASE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    entry_push_a: assert property (FLUSH |-> PUSH_PC && !LOAD_VECTOR)
        else $error("flush without push");
    vector_load_a: assert property (FLUSH |-> ##3 LOAD_VECTOR)
        else $error("vector load not three cycles after flush");
    vector_fixed_a: assert property (VECTOR_ADDR == 15'h0004)
        else $error("vector address wrong");
    take_gate_a: assert property (FLUSH |-> Q1_PHASE && INSTR_BOUNDARY && IRQ_PENDING)
        else $error("entry taken without its conditions");
    gie_clear_a: assert property (FLUSH |=> !IRQ_PENDING && !FLUSH)
        else $error("global enable not cleared on entry");
    shadow_save_a: assert property (FLUSH |=> RESTORE_W == $past(CORE_W)
        && RESTORE_STATUS == ($past(CORE_STATUS) & 8'he7)) else $error("context not saved");
    return_pop_a: assert property (RETURN_EXEC |-> POP_PC && RESTORE)
        else $error("return without pop and restore");
    phase_period_a: assert property (Q1_PHASE && RST_N |=> !Q1_PHASE [*3] ##1 Q1_PHASE)
        else $error("phase one not every four clocks");
    reset_quiet_a: assert property ($rose(RST_N) |-> !IRQ_PENDING && !FLUSH)
        else $error("interrupt live after reset");
    read_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside read slot");
    take_c: cover property (FLUSH ##3 LOAD_VECTOR);
    return_c: cover property (RETURN_EXEC);
    reset_c: cover property ($rose(RST_N));
endmodule
bind cic_core cic_core_chk cic_core_chk_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .RD(RD), .RDATA(RDATA),
    .RETURN_EXEC(RETURN_EXEC), .INSTR_BOUNDARY(INSTR_BOUNDARY), .CORE_W(CORE_W), .CORE_STATUS(CORE_STATUS),
    .FLUSH(FLUSH), .PUSH_PC(PUSH_PC), .LOAD_VECTOR(LOAD_VECTOR), .VECTOR_ADDR(VECTOR_ADDR), .POP_PC(POP_PC),
    .RESTORE(RESTORE), .RESTORE_W(RESTORE_W), .RESTORE_STATUS(RESTORE_STATUS), .IRQ_PENDING(IRQ_PENDING),
    .Q1_PHASE(Q1_PHASE));

// ### cic_core_model.sv
// processor pipeline model: instruction boundaries, live context, return pulses
`timescale 1ns/100ps
module cic_core_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        stall,
    input  wire logic        ret_req,
    output logic             instr_boundary,
    output logic             return_exec,
    output logic      [7:0]  core_w,
    output logic      [7:0]  core_status,
    output logic      [5:0]  core_bank,
    output logic      [6:0]  core_pc_high_latch,
    output logic      [31:0] core_ptrs
);
    // accumulator keeps moving so a stale capture shows
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            instr_boundary <= 1'b0;
            return_exec    <= 1'b0;
            core_w         <= 8'h00;
        end else begin
            instr_boundary <= !stall;
            return_exec    <= ret_req;
            core_w         <= core_w + 8'h01;
        end
    end
    assign core_status = 8'hff;
    assign core_bank   = 6'h1f;
    assign core_pc_high_latch = 7'h55;
    assign core_ptrs   = 32'h87654321;
endmodule

// ### cic_core_tb.sv
// self-checking testbench of the core interrupt controller
`timescale 1ns/100ps
`include "cic_consts.svh"
module cic_core_tb;
    logic        clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, pin = 1'b0, tmr = 1'b0;
    logic        sleep_s = 1'b0, stall = 1'b0, ret_req = 1'b0;
    logic [6:0]  addr = 7'h00;
    logic [7:0]  wdata = 8'h00, pchg = 8'h00, rdata, rw, rs, cw, cs;
    logic [23:0] pev = 24'h000000;
    logic        flush, load_v, ibnd, rexec, sleeping, pend;
    logic [5:0]  rb, cb;
    logic [6:0]  rp, cp;
    logic [31:0] rptr, cptr;
    int          fail_count = 0, comparisons = 0, cycles = 0, takes = 0, n;
    cic_core cic_core_inst (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .EXT_PIN(pin), .TMR_OVF(tmr), .PERIPH_EVENT(pev), .PIN_CHANGE(pchg),
        .INSTR_BOUNDARY(ibnd), .SLEEP_EXEC(sleep_s), .RETURN_EXEC(rexec), .CORE_W(cw), .CORE_STATUS(cs),
        .CORE_BANK(cb), .CORE_PC_HIGH_LATCH(cp), .CORE_PTRS(cptr), .FLUSH(flush), .PUSH_PC(), .LOAD_VECTOR(load_v),
        .VECTOR_ADDR(), .POP_PC(), .RESTORE(), .RESTORE_W(rw), .RESTORE_STATUS(rs), .RESTORE_BANK(rb),
        .RESTORE_PC_HIGH_LATCH(rp), .RESTORE_PTRS(rptr), .SLEEPING(sleeping), .IRQ_PENDING(pend), .Q1_PHASE());
    cic_core_model cic_core_model_inst (.clk(clk), .rst_n(rst_n), .stall(stall), .ret_req(ret_req),
        .instr_boundary(ibnd), .return_exec(rexec), .core_w(cw), .core_status(cs), .core_bank(cb),
        .core_pc_high_latch(cp), .core_ptrs(cptr));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk) wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk) rd_s <= 1'b0;
        #1 check("rdata", 32'(rdata), 32'(e));
    endtask
    task automatic wait_take();
        n = 0;
        #1;
        while (flush !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        check("flush", 32'(flush), 32'h1);
        repeat (3) @(posedge clk);
        #1 check("load_vector", {31'h0, load_v}, 32'h1);
    endtask
    task automatic pin_step(input logic lvl, input logic [7:0] e);
        @(posedge clk) pin <= lvl;
        tick(12);
        rd(`CIC_OFF_CTRL, e);
        wr(`CIC_OFF_CTRL, 8'h60);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (flush === 1'b1)
            takes++;
        if (cycles == 5000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        tick(20);
        rst_n <= 1'b1;
        rd(`CIC_OFF_CTRL, 8'h00);
        rd(`CIC_OFF_EDGE, 8'h01);
        rd(7'h7f, 8'h00);
        wr(`CIC_OFF_CN_EN, 8'h01);
        @(posedge clk) {tmr, pev, pchg} <= {1'b1, 24'h010101, 8'h01};
        @(posedge clk) {tmr, pev, pchg} <= '0;
        rd(`CIC_OFF_CTRL, 8'h05);
        for (int g = 0; g < 3; g++)
            rd(7'(`CIC_OFF_FL_A + g), 8'h01);
        wr(`CIC_OFF_CTRL, 8'h04);
        rd(`CIC_OFF_CTRL, 8'h05);
        wr(`CIC_OFF_CN_FLAGS, 8'h00);
        rd(`CIC_OFF_CTRL, 8'h04);
        wr(`CIC_OFF_CTRL, 8'h24);
        tick(8);
        check("takes", 32'(takes), 32'h0);
        wr(`CIC_OFF_CTRL, 8'ha4);
        wait_take();
        tick(4);
        rd(`CIC_OFF_CTRL, 8'h24);
        check("shd_status", 32'({rp, rb, rs, rptr[7:0]}), 32'({7'h55, 6'h1f, 8'he7, 8'h21}));
        rd(`CIC_OFF_SHD_PTR1H, 8'h87);
        wr(`CIC_OFF_SHD_W, 8'h5a);
        rd(`CIC_OFF_SHD_W, 8'h5a);
        wr(`CIC_OFF_CTRL, 8'h20);
        @(posedge clk) ret_req <= 1'b1;
        @(posedge clk) ret_req <= 1'b0;
        tick(2);
        check("restore_w", 32'(rw), 32'h5a);
        rd(`CIC_OFF_CTRL, 8'ha0);
        check("takes", 32'(takes), 32'h1);
        @(posedge clk) tmr <= 1'b1;
        @(posedge clk) tmr <= 1'b0;
        wait_take();
        check("latency", 32'(n <= 14), 32'h1);
        wr(`CIC_OFF_EN_A, 8'h01);
        wr(`CIC_OFF_CTRL, 8'ha0);
        tick(4);
        check("pending", {31'h0, pend}, 32'h0);
        wr(`CIC_OFF_CTRL, 8'he0);
        wait_take();
        wr(`CIC_OFF_FL_A, 8'h00);
        wr(`CIC_OFF_CTRL, 8'h60);
        pin_step(1'b1, 8'h62);
        pin_step(1'b0, 8'h60);
        wr(`CIC_OFF_EDGE, 8'h00);
        pin_step(1'b1, 8'h60);
        pin_step(1'b0, 8'h62);
        wr(`CIC_OFF_EDGE, 8'h01);
        wr(`CIC_OFF_CTRL, 8'h70);
        @(posedge clk) {stall, sleep_s} <= 2'b11;
        @(posedge clk) sleep_s <= 1'b0;
        tick(2);
        check("sleeping", {31'h0, sleeping}, 32'h1);
        @(posedge clk) pin <= 1'b1;
        tick(12);
        check("woken", {31'h0, sleeping}, 32'h0);
        rd(`CIC_OFF_CTRL, 8'h72);
        check("takes", 32'(takes), 32'h3);
        @(posedge clk) {stall, pin} <= 2'b00;
        tick(4);
        check("takes", 32'(takes), 32'h3);
        wr(`CIC_OFF_CTRL, 8'hf0);
        @(posedge clk) {stall, pin, sleep_s} <= 3'b111;
        @(posedge clk) sleep_s <= 1'b0;
        tick(16);
        check("held", 32'(takes), 32'h3);
        check("waking", {31'h0, sleeping}, 32'h0);
        @(posedge clk) stall <= 1'b0;
        wait_take();
        @(posedge clk) {rst_n, pin} <= 2'b00;
        tick(3);
        rst_n <= 1'b1;
        rd(`CIC_OFF_CTRL, 8'h00);
        give_verdict();
    end
endmodule
